// ### hw/flash_pkg.sv
// constants and carrier types for the led flash control block
// assumes a 32-bit register port with byte addresses on word boundaries
package flash_pkg;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_EVENT  = 8'h08;
	localparam logic [7:0] OFF_MASK   = 8'h0C;
	localparam logic [7:0] OFF_DAC    = 8'h10;
	localparam logic [7:0] OFF_CLEAR  = 8'h14;
	localparam logic [7:0] OFF_TEMP0  = 8'h18;
	localparam logic [7:0] OFF_TEMP1  = 8'h1C;
	localparam logic [7:0] OFF_NV0    = 8'h20; // sensor 0 words at 0x20, 0x24
	localparam logic [7:0] OFF_NV1    = 8'h28; // sensor 1 words at 0x28, 0x2C

	// widths
	localparam int DAC_W   = 8;
	localparam int TEMP_W  = 16;
	localparam int NV_WORDS = 2; // 64 bits as two 32-bit words
	localparam int SENSORS = 2;

	// control register field positions
	localparam int CTRL_RUN    = 0;
	localparam int CTRL_BYPASS = 1;
	localparam int CTRL_DISCH  = 2;
	localparam int CTRL_REFINT = 3;

	// event / mask bit positions
	localparam int EV_OVP     = 0;
	localparam int EV_ALERT0  = 1;
	localparam int EV_ALERT1  = 2;
	localparam int EV_REFUSED = 3;
	localparam int EV_W       = 4;
	localparam int CLR_OVP    = 0;

	// reset values: buck off, leds shorted, inductor discharge path on
	localparam logic [3:0] CTRL_RST = 4'h6;
	localparam logic [DAC_W-1:0] DAC_RST = 8'h00;

	typedef struct packed {
		logic refint;
		logic disch;
		logic bypass;
		logic run;
	} ctrl_t;

	typedef struct packed {
		logic              alert;
		logic [TEMP_W-1:0] temp;
	} sensor_t;

endpackage : flash_pkg

// ### hw/ovp_latch.sv
// overvoltage fault latch: edge-set from the comparator, cleared by software pulse
// assumes the comparator output is synchronous to sys_clk
`timescale 1ns/10ps
`default_nettype none
module ovp_latch (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	input  wire logic clk_en,
	// comparator and clear
	input  wire logic comp_in,
	input  wire logic clear,
	// latch state
	output logic      set_now,
	output logic      flag
);
	logic comp_prev_r;
	logic comp_prev_nxt;
	logic flag_r;
	logic flag_nxt;

	// rising comparator edge clocks a constant one into the latch
	always_comb begin
		set_now       = comp_in & ~comp_prev_r;
		comp_prev_nxt = comp_in;
		// set beats a clear arriving in the same cycle
		flag_nxt      = set_now | (flag_r & ~clear);
	end

	// prev starts high so a comparator already high at reset is no edge
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			comp_prev_r <= 1'b1;
			flag_r      <= 1'b0;
		end else if (clk_en) begin
			comp_prev_r <= comp_prev_nxt;
			flag_r      <= flag_nxt;
		end
	end

	assign flag = flag_r;
endmodule : ovp_latch
`default_nettype wire

// ### hw/nv_store.sv
// 64-bit user storage of one temperature sensor, two 32-bit words
// assumes word writes only; read is combinational, the caller registers it
`timescale 1ns/10ps
`default_nettype none
module nv_store (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	// word access
	input  wire logic        wr,
	input  wire logic        word_sel,
	input  wire logic [31:0] wdata,
	output logic      [31:0] rdata
);
	logic [31:0] mem_r [flash_pkg::NV_WORDS];
	logic [31:0] mem_nxt [flash_pkg::NV_WORDS];

	// written word takes the new value, the other keeps its own
	always_comb begin
		for (int i = 0; i < flash_pkg::NV_WORDS; i++) begin
			mem_nxt[i] = (wr && (i == int'(word_sel))) ? wdata : mem_r[i];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < flash_pkg::NV_WORDS; i++) begin
				mem_r[i] <= 32'h0000_0000;
			end
		end else if (clk_en) begin
			for (int i = 0; i < flash_pkg::NV_WORDS; i++) begin
				mem_r[i] <= mem_nxt[i];
			end
		end
	end

	assign rdata = mem_r[word_sel];
endmodule : nv_store
`default_nettype wire

// ### hw/led_flash_ctrl.sv
// digital control around a pulsed led buck stage with overvoltage latch
// assumes a single-cycle register port driven by the controller firmware,
// comparator and sensor inputs synchronous to sys_clk
//
// Overview of operation
// - discharge control high switches on the discharge transistor
// - rising comparator edge is the clock edge of the fault latch
// - on that edge the latch captures a constant one
// - a set latch forces the buck run output low whatever is requested
// - shutdown stays latched after overvoltage ends until cleared
// - latch state is shown as the overvoltage flag, firmware reports it
// - temperature readings and over-temperature alerts reach the controller
// - each sensor keeps 64 bits of writable, readable user storage
`timescale 1ns/10ps
`default_nettype none
module led_flash_ctrl (
	// clock, reset, enable
	input  wire logic                               sys_clk,
	input  wire logic                               sys_rst,
	input  wire logic                               clk_en,
	// register port
	input  wire logic [7:0]                         reg_addr,
	input  wire logic [31:0]                        reg_wdata,
	input  wire logic                               reg_wr,
	input  wire logic                               reg_rd,
	output logic      [31:0]                        reg_rdata,
	// analog front end
	input  wire logic                               ov_comp,
	input  wire flash_pkg::sensor_t [1:0]           sensor_in,
	// power stage controls
	output logic                                    buck_run,
	output logic                                    led_bypass_control,
	output logic                                    discharge_path_control,
	output logic      [flash_pkg::DAC_W-1:0]        internal_current_reference,
	output logic                                    ref_select_internal,
	// status to the controller
	output logic                                    output_overvoltage_flag,
	output logic                                    irq
);

	// address compare, used by the register and storage write decoders
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction : hit

	// word index inside a two-word storage window
	function automatic logic nv_word(input logic [7:0] a);
		return a[2];
	endfunction : nv_word

	// register state
	flash_pkg::ctrl_t                ctrl_r;
	flash_pkg::ctrl_t                ctrl_nxt;
	logic [flash_pkg::DAC_W-1:0]     dac_r;
	logic [flash_pkg::DAC_W-1:0]     dac_nxt;
	logic [flash_pkg::EV_W-1:0]      event_r;
	logic [flash_pkg::EV_W-1:0]      event_nxt;
	logic [flash_pkg::EV_W-1:0]      mask_r;
	logic [flash_pkg::EV_W-1:0]      mask_nxt;
	logic [flash_pkg::SENSORS-1:0]   alert_prev_r;
	logic [flash_pkg::SENSORS-1:0]   alert_prev_nxt;

	// output state
	logic                            run_out_r;
	logic                            run_out_nxt;
	logic                            bypass_out_r;
	logic                            bypass_out_nxt;
	logic                            disch_out_r;
	logic                            disch_out_nxt;
	logic [flash_pkg::DAC_W-1:0]     dac_out_r;
	logic                            refint_out_r;
	logic                            flag_out_r;
	logic                            flag_out_nxt;
	logic                            irq_r;
	logic                            irq_nxt;
	logic [31:0]                     rdata_r;
	logic [31:0]                     rdata_nxt;

	// decode and event wires
	logic                            wr_ctrl;
	logic                            wr_event;
	logic                            wr_mask;
	logic                            wr_dac;
	logic                            wr_clear;
	logic                            ovp_clear;
	logic                            ovp_set_now;
	logic                            ovp_flag;
	logic                            ovp_active;
	logic [flash_pkg::SENSORS-1:0]   nv_wr;
	logic [flash_pkg::SENSORS-1:0]   alert_rise;
	logic [flash_pkg::EV_W-1:0]      ev_in;
	logic [31:0]                     nv_rdata [flash_pkg::SENSORS];

	// write strobes per register
	always_comb begin
		wr_ctrl  = reg_wr && hit(reg_addr, flash_pkg::OFF_CTRL);
		wr_event = reg_wr && hit(reg_addr, flash_pkg::OFF_EVENT);
		wr_mask  = reg_wr && hit(reg_addr, flash_pkg::OFF_MASK);
		wr_dac   = reg_wr && hit(reg_addr, flash_pkg::OFF_DAC);
		wr_clear = reg_wr && hit(reg_addr, flash_pkg::OFF_CLEAR);
		// acknowledgement from firmware clears the fault latch
		ovp_clear = wr_clear && reg_wdata[flash_pkg::CLR_OVP];
	end

	// overvoltage fault latch
	ovp_latch u_ovp (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.comp_in (ov_comp),
		.clear   (ovp_clear),
		.set_now (ovp_set_now),
		.flag    (ovp_flag)
	);

	// next latch state: the edge blocks run at once, a clear frees it at once
	assign ovp_active = ovp_set_now | (ovp_flag & ~ovp_clear);

	// per-sensor user storage and alert edges
	genvar g;
	generate
		for (g = 0; g < flash_pkg::SENSORS; g++) begin : g_sensor
			logic [7:0] base;
			assign base = (g == 0) ? flash_pkg::OFF_NV0 : flash_pkg::OFF_NV1;
			// either word of the window selects this store
			assign nv_wr[g] = reg_wr && (hit({reg_addr[7:3], 3'h0}, base));
			assign alert_rise[g] = sensor_in[g].alert & ~alert_prev_r[g];
			nv_store u_nv (
				.sys_clk  (sys_clk),
				.sys_rst  (sys_rst),
				.clk_en   (clk_en),
				.wr       (nv_wr[g]),
				.word_sel (nv_word(reg_addr)),
				.wdata    (reg_wdata),
				.rdata    (nv_rdata[g])
			);
		end
	endgenerate

	// control and reference registers
	always_comb begin
		ctrl_nxt = ctrl_r;
		dac_nxt  = dac_r;
		mask_nxt = mask_r;
		if (wr_ctrl) begin
			ctrl_nxt = flash_pkg::ctrl_t'(reg_wdata[3:0]);
		end
		if (wr_dac) begin
			dac_nxt = reg_wdata[flash_pkg::DAC_W-1:0];
		end
		if (wr_mask) begin
			mask_nxt = reg_wdata[flash_pkg::EV_W-1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ctrl_r <= flash_pkg::ctrl_t'(flash_pkg::CTRL_RST);
			dac_r  <= flash_pkg::DAC_RST;
			mask_r <= '0;
		end else if (clk_en) begin
			ctrl_r <= ctrl_nxt;
			dac_r  <= dac_nxt;
			mask_r <= mask_nxt;
		end
	end

	// sticky events; a new event wins over a write-one clear
	always_comb begin
		ev_in = '0;
		ev_in[flash_pkg::EV_OVP]    = ovp_set_now;
		ev_in[flash_pkg::EV_ALERT0] = alert_rise[0];
		ev_in[flash_pkg::EV_ALERT1] = alert_rise[1];
		// run asked for while latched: flagged so firmware sees the refusal
		ev_in[flash_pkg::EV_REFUSED] = ctrl_nxt.run & ovp_active;
		event_nxt = event_r;
		if (wr_event) begin
			event_nxt = event_nxt & ~reg_wdata[flash_pkg::EV_W-1:0];
		end
		event_nxt = event_nxt | ev_in;
		alert_prev_nxt = {sensor_in[1].alert, sensor_in[0].alert};
		// level interrupt, tracks the sticky bits with no extra delay
		irq_nxt = |(event_nxt & mask_nxt);
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			event_r      <= '0;
			alert_prev_r <= '0;
			irq_r        <= 1'b0;
		end else if (clk_en) begin
			event_r      <= event_nxt;
			alert_prev_r <= alert_prev_nxt;
			irq_r        <= irq_nxt;
		end
	end

	// power stage drive, all outputs registered to avoid glitches on gates
	always_comb begin
		// nor of inverted request and latch: fault overrides firmware
		run_out_nxt    = ctrl_nxt.run & ~ovp_active;
		bypass_out_nxt = ctrl_nxt.bypass;
		// high turns the discharge transistor on
		disch_out_nxt  = ctrl_nxt.disch;
		// flag and run move on the same edge, so firmware never sees them disagree
		flag_out_nxt   = ovp_active;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			run_out_r    <= 1'b0;
			bypass_out_r <= 1'b1;
			disch_out_r  <= 1'b1;
			dac_out_r    <= flash_pkg::DAC_RST;
			refint_out_r <= 1'b0;
			flag_out_r   <= 1'b0;
		end else if (clk_en) begin
			run_out_r    <= run_out_nxt;
			bypass_out_r <= bypass_out_nxt;
			disch_out_r  <= disch_out_nxt;
			dac_out_r    <= dac_nxt;
			refint_out_r <= ctrl_nxt.refint;
			flag_out_r   <= flag_out_nxt;
		end
	end

	// read mux; data stands only in the cycle after the strobe
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				flash_pkg::OFF_CTRL: begin
					rdata_nxt[3:0] = ctrl_r;
				end
				flash_pkg::OFF_STATUS: begin
					rdata_nxt[0] = ovp_flag;
					rdata_nxt[1] = run_out_r;
					rdata_nxt[2] = sensor_in[0].alert;
					rdata_nxt[3] = sensor_in[1].alert;
				end
				flash_pkg::OFF_EVENT: begin
					rdata_nxt[flash_pkg::EV_W-1:0] = event_r;
				end
				flash_pkg::OFF_MASK: begin
					rdata_nxt[flash_pkg::EV_W-1:0] = mask_r;
				end
				flash_pkg::OFF_DAC: begin
					rdata_nxt[flash_pkg::DAC_W-1:0] = dac_r;
				end
				flash_pkg::OFF_TEMP0: begin
					rdata_nxt[flash_pkg::TEMP_W-1:0] = sensor_in[0].temp;
				end
				flash_pkg::OFF_TEMP1: begin
					rdata_nxt[flash_pkg::TEMP_W-1:0] = sensor_in[1].temp;
				end
				flash_pkg::OFF_NV0, 8'h24: begin
					rdata_nxt = nv_rdata[0];
				end
				flash_pkg::OFF_NV1, 8'h2C: begin
					rdata_nxt = nv_rdata[1];
				end
				default: begin
					rdata_nxt = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rdata_r <= 32'h0000_0000;
		end else if (clk_en) begin
			rdata_r <= rdata_nxt;
		end
	end

	// port drive
	assign buck_run                   = run_out_r;
	assign led_bypass_control         = bypass_out_r;
	assign discharge_path_control     = disch_out_r;
	assign internal_current_reference = dac_out_r;
	assign ref_select_internal        = refint_out_r;
	assign output_overvoltage_flag    = flag_out_r;
	assign irq                        = irq_r;
	assign reg_rdata                  = rdata_r;

endmodule : led_flash_ctrl
`default_nettype wire

// ### verif/sensor_front.sv
// front-end model: overvoltage comparator and two temperature sensors
// assumes the bench sets the analog conditions; outputs move on sys_clk
`timescale 1ns/10ps
`default_nettype none
module sensor_front (
	// clock
	input  wire logic                sys_clk,
	// analog conditions from the bench
	input  wire logic                ov_level,
	input  wire logic [1:0]          alert_set,
	input  wire logic [15:0]         t0,
	input  wire logic [15:0]         t1,
	// towards the block
	output logic                     ov_comp,
	output flash_pkg::sensor_t [1:0] sensor_in
);
	// outputs lag the conditions by one cycle, like a real comparator path
	always_ff @(posedge sys_clk) begin
		ov_comp <= ov_level;
		sensor_in[0] <= {alert_set[0], t0};
		sensor_in[1] <= {alert_set[1], t1};
	end
endmodule : sensor_front
`default_nettype wire

// ### verif/led_flash_ctrl_props.sv
// port assertions for the led flash control block
// assumes clk_en high while the checked strobes occur
`timescale 1ns/10ps
`default_nettype none
module led_flash_ctrl_props (
	// clock and reset
	input wire logic                     sys_clk,
	input wire logic                     sys_rst,
	input wire logic                     clk_en,
	// register port
	input wire logic [7:0]               reg_addr,
	input wire logic [31:0]              reg_wdata,
	input wire logic                     reg_wr,
	input wire logic                     reg_rd,
	input wire logic [31:0]              reg_rdata,
	// front end and outputs
	input wire logic                     ov_comp,
	input wire flash_pkg::sensor_t [1:0] sensor_in,
	input wire logic                     buck_run,
	input wire logic                     discharge_path_control,
	input wire logic [7:0]               internal_current_reference,
	input wire logic                     output_overvoltage_flag
);
	logic [31:0]              wd_q;
	flash_pkg::sensor_t [1:0] sq;
	// last write data and sensor view, for one-cycle-later compares
	always_ff @(posedge sys_clk) begin
		wd_q <= reg_wdata;
		sq <= sensor_in;
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	ov_set_a: assert property ($rose(ov_comp) && clk_en && !$past(sys_rst) |=> output_overvoltage_flag && !buck_run)
		else $error("flag not set after comparator rise");
	run_off_a: assert property (output_overvoltage_flag |-> !buck_run)
		else $error("buck run high while latched");
	flag_hold_a: assert property (output_overvoltage_flag && !(reg_wr && reg_addr == flash_pkg::OFF_CLEAR && reg_wdata[0]) |=> output_overvoltage_flag)
		else $error("latch dropped without clear");
	flag_clear_a: assert property (reg_wr && clk_en && reg_addr == flash_pkg::OFF_CLEAR && reg_wdata[0] && !$rose(ov_comp) |=> !output_overvoltage_flag)
		else $error("latch not cleared");
	disch_follow_a: assert property (reg_wr && clk_en && reg_addr == flash_pkg::OFF_CTRL |=> discharge_path_control == wd_q[2])
		else $error("discharge control wrong");
	run_follow_a: assert property (reg_wr && clk_en && reg_addr == flash_pkg::OFF_CTRL && !output_overvoltage_flag && !ov_comp |=> buck_run == wd_q[0])
		else $error("buck run wrong");
	dac_follow_a: assert property (reg_wr && clk_en && reg_addr == flash_pkg::OFF_DAC |=> internal_current_reference == wd_q[7:0])
		else $error("dac code wrong");
	temp_read_a: assert property (reg_rd && clk_en && reg_addr == flash_pkg::OFF_TEMP0 |=> reg_rdata == {16'h0000, sq[0].temp})
		else $error("temperature read wrong");
endmodule : led_flash_ctrl_props
bind led_flash_ctrl led_flash_ctrl_props props_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .ov_comp(ov_comp), .sensor_in(sensor_in),
	.buck_run(buck_run), .discharge_path_control(discharge_path_control),
	.internal_current_reference(internal_current_reference),
	.output_overvoltage_flag(output_overvoltage_flag));
`default_nettype wire

// ### verif/test_led_flash_ctrl.sv
// self-checking bench for the led flash control block
// assumes the package, front-end model and checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module test_led_flash_ctrl;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic clk_en = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata, q, v;
	logic ov_comp, ov_level = 1'b0;
	logic [1:0] alert_set = 2'h0;
	logic [15:0] t0 = 16'h0, t1 = 16'h0;
	flash_pkg::sensor_t [1:0] sensor_in;
	logic buck_run, bypass, disch, ref_int, flag, irq;
	logic [7:0] dac;
	logic [31:0] nv [4];
	int fail_count = 0, checked = 0;
	// 250 MHz
	always #2 sys_clk = ~sys_clk;
	sensor_front u_front (.sys_clk(sys_clk), .ov_level(ov_level), .alert_set(alert_set),
		.t0(t0), .t1(t1), .ov_comp(ov_comp), .sensor_in(sensor_in));
	led_flash_ctrl DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ov_comp(ov_comp), .sensor_in(sensor_in), .buck_run(buck_run),
		.led_bypass_control(bypass), .discharge_path_control(disch),
		.internal_current_reference(dac), .ref_select_internal(ref_int),
		.output_overvoltage_flag(flag), .irq(irq));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one register access; read data lands in q one cycle after the strobe
	task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= wr;
		reg_rd <= !wr;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1 q = reg_rdata;
	endtask : acc
	function automatic logic [31:0] status_exp(input logic fl, run, a0, a1);
		return {28'h0, a1, a0, run, fl};
	endfunction : status_exp
	task automatic tally_and_finish;
		$display("comparisons %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	// hang guard
	initial begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		tally_and_finish();
	end
	initial begin
		v = $urandom(19);
		repeat (20) @(posedge sys_clk);
		sys_rst <= 1'b0;
		#1 chk({18'h0, dac, buck_run, bypass, disch, ref_int, flag, irq}, 32'h18);
		acc(1'b0, flash_pkg::OFF_CTRL, 32'h0);
		chk(q, {28'h0, flash_pkg::CTRL_RST});
		$display("test reset done");
		// corner control codes 0 and F first, dac corner code FF in the second pass, random codes otherwise
		for (int i = 0; i < 8; i++) begin
			v = (i > 1) ? ($urandom & 32'hF) : (i ? 32'hF : 32'h0);
			acc(1'b1, flash_pkg::OFF_CTRL, v);
			chk({28'h0, ref_int, disch, bypass, buck_run}, v);
			acc(1'b0, flash_pkg::OFF_CTRL, 32'h0);
			chk(q, v);
			v = (i == 1) ? 32'hFF : ($urandom & 32'hFF);
			acc(1'b1, flash_pkg::OFF_DAC, v);
			chk({24'h0, dac}, v);
		end
		$display("test control done");
		// all four storage words written before any is read back
		for (int s = 0; s < 4; s++) begin
			nv[s] = $urandom;
			acc(1'b1, flash_pkg::OFF_NV0 + 8'(4 * s), nv[s]);
		end
		for (int s = 0; s < 4; s++) begin
			acc(1'b0, flash_pkg::OFF_NV0 + 8'(4 * s), 32'h0);
			chk(q, nv[s]);
		end
		$display("test storage done");
		acc(1'b1, flash_pkg::OFF_CTRL, 32'h1);
		acc(1'b1, flash_pkg::OFF_MASK, 32'h6);
		@(posedge sys_clk);
		t0 <= $urandom;
		t1 <= $urandom;
		repeat (3) @(posedge sys_clk);
		acc(1'b1, flash_pkg::OFF_EVENT, 32'hF);
		acc(1'b0, flash_pkg::OFF_TEMP0, 32'h0);
		chk(q, {16'h0, t0});
		acc(1'b0, flash_pkg::OFF_TEMP1, 32'h0);
		chk(q, {16'h0, t1});
		@(posedge sys_clk);
		alert_set <= 2'h2;
		repeat (3) @(posedge sys_clk);
		acc(1'b0, flash_pkg::OFF_EVENT, 32'h0);
		chk({q[30:0], irq}, 32'h9);
		acc(1'b0, flash_pkg::OFF_STATUS, 32'h0);
		chk(q, status_exp(1'b0, 1'b1, 1'b0, 1'b1));
		acc(1'b1, flash_pkg::OFF_EVENT, 32'h4);
		chk(irq, 32'h0);
		$display("test sensors done");
		// one flash: precharge with leds shorted, leds on, then discharge
		acc(1'b1, flash_pkg::OFF_CTRL, 32'h3);
		chk({28'h0, ref_int, disch, bypass, buck_run}, 32'h3);
		acc(1'b1, flash_pkg::OFF_CTRL, 32'h1);
		chk({28'h0, ref_int, disch, bypass, buck_run}, 32'h1);
		repeat (8) @(posedge sys_clk);
		acc(1'b1, flash_pkg::OFF_CTRL, 32'h6);
		chk({28'h0, ref_int, disch, bypass, buck_run}, 32'h6);
		acc(1'b1, flash_pkg::OFF_CTRL, 32'h1);
		$display("test flash done");
		acc(1'b1, flash_pkg::OFF_MASK, 32'h1);
		@(posedge sys_clk);
		ov_level <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 chk({flag, buck_run, irq, disch}, 32'hA);
		@(posedge sys_clk);
		ov_level <= 1'b0;
		repeat (10) @(posedge sys_clk);
		#1 chk({flag, buck_run, irq}, 32'h5);
		acc(1'b1, flash_pkg::OFF_CTRL, 32'h1);
		chk(buck_run, 32'h0);
		acc(1'b0, flash_pkg::OFF_EVENT, 32'h0);
		chk(q, 32'h9);
		acc(1'b0, flash_pkg::OFF_STATUS, 32'h0);
		chk(q, status_exp(1'b1, 1'b0, 1'b0, 1'b1));
		acc(1'b1, flash_pkg::OFF_CLEAR, 32'h1);
		chk({flag, buck_run, irq}, 32'h3);
		acc(1'b1, flash_pkg::OFF_EVENT, 32'hF);
		chk(irq, 32'h0);
		acc(1'b0, flash_pkg::OFF_CLEAR, 32'h0);
		chk(q, 32'h0);
		acc(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
		$display("test overvoltage done");
		tally_and_finish();
	end
endmodule : test_led_flash_ctrl
`default_nettype wire
